//--- rfp_fifo.sv
// Purpose: Synchronous RAM FIFO with push/pop arbiter and flags
// Assumes: Every RAM cycle starts on a rising mclk edge
// Notes: RAM rewritten every cycle; banks chosen by address MSBs
//
// How it works
// - Push/pop advance write/read location in order
// - Flag empty when none, full when all, or all but one in fast mode
// - Blocked favoured request yields to the other
// - RAM written every cycle, mux keeps old
// - Bank select limits write; read mux
// - Active register used, inactive holds other
// - Four-bit code: inc, inc-swap, hold, swap
// - Flags change only on active cycles
// - Equality on push: full; pop: empty
// - Comparator result gated by write, registered
// - Set flag clears on next opposite cycle
// - Single request wins; both use tie-break
// - Active only if push unfull, pop unempty
// - Inactive cycle forces write indication low
// - Push accept when push served that cycle
// - Pop accept; data ends that cycle
// - Tie-break high, low, full or empty
// - Write-driven tie-break alternates writes, reads
// - Burst option repeats last operation
// - Fast mode: every cycle writes input, pop cycles at the read address
`timescale 1ns/1ps
`default_nettype none
module rfp_fifo import rfp_pkg::*; #(
    parameter int unsigned DEPTH = RFP_DEPTH,
    parameter int unsigned BANKS = RFP_BANKS,
    parameter int unsigned DW = RFP_DW
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Producer
    input wire logic push_req,
    input wire logic [DW-1:0] push_data,
    output logic push_ack,
    // Consumer
    input wire logic pop_req,
    output logic pop_rdy,
    output logic [DW-1:0] pop_data,
    // Tie-break and flags
    input wire logic tie_break,
    output logic full,
    output logic empty
);
    localparam int unsigned AW = $clog2(DEPTH);
    localparam int unsigned BW = $clog2(BANKS);
    localparam int unsigned OW = AW - BW;
    localparam int unsigned BD = DEPTH / BANKS;

    logic [AW-1:0] act_addr;
    logic [AW-1:0] inact_addr;
    logic act_is_wr;
    logic cur_active;
    logic cur_wr;
    logic [DW-1:0] in_word;
    logic [2:0] prio_mode;
    logic fast_mode;
    logic [3:0] addr_code;
    logic [BANKS-1:0][DW-1:0] bank_word;
    logic prio_w;
    logic [3:0] next_code;
    rfp_addr_op_t addr_op;

    // Comparator sees incremented active and inactive address
    wire [AW-1:0] act_inc = act_addr + 1'b1;
    wire [AW-1:0] act_inc2 = act_addr + 2'd2;
    wire [AW-1:0] waddr = act_is_wr ? act_addr : inact_addr;
    wire [AW-1:0] raddr = act_is_wr ? inact_addr : act_addr;
    // Fast mode needs one spare location for junk writes
    wire [AW-1:0] cmp_addr = (fast_mode && cur_wr) ? act_inc2 : act_inc;
    wire addr_eq = (cmp_addr == inact_addr);
    wire set_full = cur_active & cur_wr & addr_eq;
    wire set_empty = cur_active & ~cur_wr & addr_eq;
    wire next_full = cur_active ? set_full : full;
    wire next_empty = cur_active ? set_empty : empty;

    // Arbitration
    wire can_push = push_req & ~next_full;
    wire can_pop = pop_req & ~next_empty;
    wire both = push_req & pop_req;
    wire pick_both = prio_w ? (can_push | ~can_pop) : (~can_pop & can_push);
    wire pick_wr = both ? pick_both : push_req;
    wire next_active = pick_wr ? can_push : can_pop;
    wire next_wr = next_active & pick_wr;
    wire next_rd = next_active & ~pick_wr;
    wire same_side = (act_is_wr == next_wr);

    always_comb begin
        unique case (prio_mode)
            PRIO_WRITE: prio_w = 1'b1;
            PRIO_READ: prio_w = 1'b0;
            PRIO_FULL: prio_w = ~next_full;
            PRIO_EMPTY: prio_w = next_empty;
            PRIO_ALT: prio_w = ~cur_wr;
            PRIO_BURST: prio_w = cur_wr;
            PRIO_PIN: prio_w = tie_break;
            default: prio_w = tie_break;
        endcase
    end

    // Table row: active register side, activity, next side
    always_comb begin
        if (cur_active) begin
            addr_op = same_side ? ADDR_INC_KEEP : ADDR_INC_SWAP;
        end else begin
            addr_op = same_side ? ADDR_HOLD : ADDR_SWAP;
        end
    end

    always_comb begin
        unique case (addr_op)
            ADDR_INC_KEEP: next_code = ADDR_CODE_INC_KEEP;
            ADDR_INC_SWAP: next_code = ADDR_CODE_INC_SWAP;
            ADDR_SWAP: next_code = ADDR_CODE_SWAP;
            ADDR_HOLD: next_code = ADDR_CODE_HOLD;
        endcase
    end

    // Address registers
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            act_addr <= '0;
            inact_addr <= '0;
            act_is_wr <= 1'b1;
            addr_code <= ADDR_CODE_HOLD;
        end else begin
            unique case (addr_op)
                ADDR_INC_KEEP: act_addr <= act_inc;
                ADDR_INC_SWAP: begin
                    act_addr <= inact_addr;
                    inact_addr <= act_inc;
                end
                ADDR_SWAP: begin
                    act_addr <= inact_addr;
                    inact_addr <= act_addr;
                end
                ADDR_HOLD: act_addr <= act_addr;
            endcase
            act_is_wr <= next_wr;
            addr_code <= next_code;
        end
    end

    // Cycle state, flags and handshakes
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cur_active <= 1'b0;
            cur_wr <= 1'b0;
            full <= 1'b0;
            empty <= 1'b1;
            push_ack <= 1'b0;
            pop_rdy <= 1'b0;
        end else begin
            cur_active <= next_active;
            cur_wr <= next_wr;
            full <= next_full;
            empty <= next_empty;
            push_ack <= next_wr;
            pop_rdy <= next_rd;
        end
    end

    // Input word captured at the edge that starts the push cycle
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            in_word <= '0;
        end else if (fast_mode || next_wr) begin
            in_word <= push_data;
        end
    end

    // Idle cycles in fast mode must land on the write address
    wire pop_cycle = cur_active & ~cur_wr;
    wire [AW-1:0] ram_addr = (fast_mode && !pop_cycle) ? waddr : act_addr;
    wire [BW-1:0] bank_sel = ram_addr[AW-1 -: BW];
    wire [OW-1:0] bank_off = ram_addr[OW-1:0];
    wire new_word = fast_mode | (cur_active & cur_wr);

    genvar b;
    generate
        for (b = 0; b < BANKS; b++) begin : g_bank
            logic [DW-1:0] bank_mem [BD];
            wire bank_hit = (bank_sel == BW'(b));
            always_ff @(posedge mclk) begin
                bank_mem[bank_off] <= (bank_hit && new_word) ? in_word : bank_mem[bank_off];
            end
            assign bank_word[b] = bank_mem[bank_off];
        end
    endgenerate

    wire [DW-1:0] rd_word = bank_word[bank_sel];

    // Output word only moves on pops
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pop_data <= '0;
        end else if (pop_cycle) begin
            pop_data <= rd_word;
        end
    end

    // Register port
    wire ctrl_hit = (reg_addr == REG_CTRL);
    wire [31:0] ctrl_word = {28'h0, fast_mode, prio_mode};
    wire [31:0] stat_word = {28'h0, cur_wr, cur_active, full, empty};
    wire [31:0] addr_word = {16'h0, 8'(inact_addr), 8'(act_addr)};
    wire [31:0] code_word = {28'h0, addr_code};
    wire [31:0] rd_mux = ctrl_hit ? ctrl_word :
                         (reg_addr == REG_STATUS) ? stat_word :
                         (reg_addr == REG_ADDR) ? addr_word :
                         (reg_addr == REG_CODE) ? code_word : 32'h0;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            prio_mode <= PRIO_RESET;
            fast_mode <= 1'b0;
        end else if (reg_wr && ctrl_hit) begin
            prio_mode <= reg_wdata[CTRL_PRIO_LSB +: 3];
            fast_mode <= reg_wdata[CTRL_FAST_BIT];
        end
    end

    // Unmapped or idle reads return zero
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            reg_rdata <= 32'h0;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : 32'h0;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    property p_wr_adv;
        cur_active && cur_wr |=> waddr == AW'($past(waddr) + 1'b1);
    endproperty
    a_wr_adv: assert property (p_wr_adv) else $error("write address did not advance");

    property p_rd_adv;
        pop_cycle |=> raddr == AW'($past(raddr) + 1'b1);
    endproperty
    a_rd_adv: assert property (p_rd_adv) else $error("read address did not advance");

    property p_full_set;
        set_full |=> full && !empty;
    endproperty
    a_full_set: assert property (p_full_set) else $error("full not raised");

    property p_empty_set;
        set_empty |=> empty && !full;
    endproperty
    a_empty_set: assert property (p_empty_set) else $error("empty not raised");

    property p_flag_hold;
        !cur_active |=> $stable(full) && $stable(empty);
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag moved on idle cycle");

    property p_idle_addr;
        !cur_active |=> $stable(waddr) && $stable(raddr);
    endproperty
    a_idle_addr: assert property (p_idle_addr) else $error("address moved on idle cycle");

    property p_no_bad_op;
        (push_ack |-> !$past(next_full)) and (pop_rdy |-> !$past(next_empty));
    endproperty
    a_no_bad_op: assert property (p_no_bad_op) else $error("served op on full or empty");

    property p_override;
        both && !can_push && can_pop |-> next_rd;
    endproperty
    a_override: assert property (p_override) else $error("blocked side not overridden");

    property p_ack;
        push_ack |-> cur_active && cur_wr && $past(push_req);
    endproperty
    a_ack: assert property (p_ack) else $error("push accept without push cycle");

    sequence s_pop_cycle;
        pop_rdy && pop_cycle;
    endsequence
    sequence s_pop_out;
        ##1 pop_data == $past(rd_word);
    endsequence
    property p_pop_data;
        s_pop_cycle |-> s_pop_out;
    endproperty
    a_pop_data: assert property (p_pop_data) else $error("popped word not presented");

    property p_alt;
        prio_mode == PRIO_ALT && cur_active && cur_wr && both && can_pop |-> next_rd;
    endproperty
    a_alt: assert property (p_alt) else $error("write not followed by read");

    property p_burst;
        prio_mode == PRIO_BURST && cur_active && cur_wr && both && can_push |-> next_wr;
    endproperty
    a_burst: assert property (p_burst) else $error("burst write not repeated");

    // Idle cycles must never look like writes
    property p_idle_rd;
        !cur_active |-> !cur_wr;
    endproperty
    a_idle_rd: assert property (p_idle_rd) else $error("write flagged on idle cycle");

    property p_one_op;
        !(push_ack && pop_rdy);
    endproperty
    a_one_op: assert property (p_one_op) else $error("push and pop served together");

    property p_empty_exit;
        empty && cur_active |-> cur_wr;
    endproperty
    a_empty_exit: assert property (p_empty_exit) else $error("empty left by a pop");

    property p_full_exit;
        full && cur_active |-> !cur_wr;
    endproperty
    a_full_exit: assert property (p_full_exit) else $error("full left by a push");

    // Lone requests with room must always be served
    property p_lone_push;
        push_req && !pop_req && !next_full |=> push_ack;
    endproperty
    a_lone_push: assert property (p_lone_push) else $error("lone push not served");

    property p_lone_pop;
        pop_req && !push_req && !next_empty |=> pop_rdy;
    endproperty
    a_lone_pop: assert property (p_lone_pop) else $error("lone pop not served");

    property p_code_swap;
        cur_active && !same_side |=> addr_code == ADDR_CODE_INC_SWAP;
    endproperty
    a_code_swap: assert property (p_code_swap) else $error("wrong code on direction change");
endmodule
`default_nettype wire

//--- rfp_peer.sv
// Purpose: Producer and consumer stand-in for the FIFO
// Assumes: Requests are levels that change just after rising edges
// Notes: Word changes every cycle, so a stale word is never taken twice unseen
`timescale 1ns/1ps
`default_nettype none
module rfp_peer import rfp_pkg::*; (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Bench control, stall by dropping these
    input wire logic go_push,
    input wire logic go_pop,
    // Fifo side
    output logic push_req,
    output logic [RFP_DW-1:0] push_data,
    output logic pop_req
);
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            push_req <= 1'b0;
            pop_req <= 1'b0;
            push_data <= RFP_DW'(8'hA5);
        end else begin
            push_req <= go_push;
            pop_req <= go_pop;
            push_data <= push_data + 1'b1;
        end
    end
endmodule
`default_nettype wire

//--- rfp_pkg.sv
// Purpose: Constants for the RAM FIFO with push/pop arbitration
// Assumes: One clock, register port with 4-bit byte address
// Notes: Register offsets and mode codes are local choices
package rfp_pkg;
    // Storage shape
    localparam int unsigned RFP_DEPTH = 16;
    localparam int unsigned RFP_BANKS = 2;
    localparam int unsigned RFP_DW = 8;
    // Register offsets
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_ADDR = 4'h8;
    localparam logic [3:0] REG_CODE = 4'hC;
    // Control fields
    localparam int unsigned CTRL_PRIO_LSB = 0;
    localparam int unsigned CTRL_FAST_BIT = 3;
    // Status fields
    localparam int unsigned STAT_EMPTY_BIT = 0;
    localparam int unsigned STAT_FULL_BIT = 1;
    localparam int unsigned STAT_ACTIVE_BIT = 2;
    localparam int unsigned STAT_WRITE_BIT = 3;
    // Address register field
    localparam int unsigned ADDR_INACT_LSB = 8;
    // Tie-break modes
    localparam logic [2:0] PRIO_WRITE = 3'h0;
    localparam logic [2:0] PRIO_READ = 3'h1;
    localparam logic [2:0] PRIO_FULL = 3'h2;
    localparam logic [2:0] PRIO_EMPTY = 3'h3;
    localparam logic [2:0] PRIO_ALT = 3'h4;
    localparam logic [2:0] PRIO_BURST = 3'h5;
    localparam logic [2:0] PRIO_PIN = 3'h6;
    localparam logic [2:0] PRIO_RESET = PRIO_EMPTY;
    // Address control codes
    localparam logic [3:0] ADDR_CODE_INC_KEEP = 4'hB;
    localparam logic [3:0] ADDR_CODE_INC_SWAP = 4'hD;
    localparam logic [3:0] ADDR_CODE_SWAP = 4'h5;
    localparam logic [3:0] ADDR_CODE_HOLD = 4'h0;
    typedef enum logic [1:0] {
        ADDR_HOLD,
        ADDR_INC_KEEP,
        ADDR_INC_SWAP,
        ADDR_SWAP
    } rfp_addr_op_t;
endpackage

//--- test_rfp_fifo.sv
// Purpose: Self-checking bench for the RAM FIFO
// Assumes: Default depth and banks, pop data checked by a scoreboard
// Notes: Mode windows are short so the fill level never hits a flag
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, a) begin n_compared++; if ((a) !== (e)) begin failures++; \
    $display("ERROR %s exp %0h got %0h", nm, (e), (a)); end end
module test_rfp_fifo import rfp_pkg::*;;
    logic mclk, rst_n, reg_wr, reg_rd, push_req, push_ack, pop_req, pop_rdy, tie_break, full, empty;
    logic go_push, go_pop, pend;
    logic [3:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, d;
    logic [RFP_DW-1:0] push_data, pop_data, prev;
    logic [RFP_DW-1:0] sb [$];
    logic [2:0] md [8] = '{PRIO_WRITE, PRIO_FULL, PRIO_PIN, PRIO_READ, PRIO_EMPTY, PRIO_PIN, PRIO_ALT, PRIO_BURST};
    int failures = 0, n_compared = 0, na, nr, nsw, lastop;
    rfp_fifo u_dut (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .push_req(push_req),
        .push_data(push_data), .push_ack(push_ack), .pop_req(pop_req), .pop_rdy(pop_rdy),
        .pop_data(pop_data), .tie_break(tie_break), .full(full), .empty(empty));
    rfp_peer u_peer (.mclk(mclk), .rst_n(rst_n), .go_push(go_push), .go_pop(go_pop),
        .push_req(push_req), .push_data(push_data), .pop_req(pop_req));
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    // Scoreboard: word taken at the edge before the ack, shown one cycle after the pop edge
    always @(posedge mclk) begin
        if (rst_n) begin
            if (pend) `CHK("pop_data", (sb.size() ? sb.pop_front() : 8'hXX), pop_data)
            if (push_ack === 1'b1) sb.push_back(prev);
            `CHK("ack_rdy_excl", 1'b0, push_ack & pop_rdy)
            pend <= pop_rdy;
        end
        prev <= push_data;
    end
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        d = reg_rdata;
        @(posedge mclk);
    endtask
    // Fixed window; counts served pushes, pops and changes of direction
    task automatic run(input logic p, input logic q, input int n);
        go_push <= p;
        go_pop <= q;
        na = 0;
        nr = 0;
        nsw = 0;
        lastop = 0;
        repeat (n) begin
            @(negedge mclk);
            if (push_ack === 1'b1) begin
                if (lastop == 2) nsw++;
                lastop = 1;
                na++;
            end
            if (pop_rdy === 1'b1) begin
                if (lastop == 1) nsw++;
                lastop = 2;
                nr++;
            end
        end
        @(posedge mclk);
    endtask
    task automatic t_reset;
        `CHK("empty", 1'b1, empty)
        `CHK("full", 1'b0, full)
        rd(REG_STATUS);
        `CHK("status", 32'h1, d)
        rd(REG_ADDR);
        `CHK("addr", 32'h0, d)
        rd(REG_CTRL);
        `CHK("ctrl", {29'h0, PRIO_RESET}, d)
        rd(REG_CODE);
        `CHK("code", {28'h0, ADDR_CODE_HOLD}, d)
        wr(REG_STATUS, 32'hF);
        rd(4'h2);
        `CHK("unmapped", 32'h0, d)
        rd(REG_STATUS);
        `CHK("status_ro", 32'h1, d)
        $display("test reset done");
    endtask
    task automatic t_fill(input logic fast);
        int cap;
        cap = fast ? RFP_DEPTH - 1 : RFP_DEPTH;
        run(1'b0, 1'b0, 3);
        wr(REG_CTRL, {28'h0, fast, PRIO_WRITE});
        run(1'b1, 1'b0, 40);
        `CHK("push_count", cap, na)
        `CHK("full", 1'b1, full)
        `CHK("empty", 1'b0, empty)
        run(1'b0, 1'b1, 40);
        `CHK("pop_count", cap, nr)
        `CHK("empty", 1'b1, empty)
        `CHK("full", 1'b0, full)
        `CHK("left", 0, sb.size())
        $display("test fill fast=%0d done", fast);
    endtask
    task automatic t_override;
        run(1'b1, 1'b0, 40);
        run(1'b0, 1'b0, 3);
        run(1'b1, 1'b1, 4);
        `CHK("pop_when_full", 1'b1, nr > 0)
        run(1'b0, 1'b1, 40);
        wr(REG_CTRL, {29'h0, PRIO_READ});
        run(1'b1, 1'b1, 4);
        `CHK("push_when_empty", 1'b1, na > 0)
        run(1'b0, 1'b1, 40);
        $display("test override done");
    endtask
    task automatic t_modes;
        for (int i = 0; i < 8; i++) begin
            tie_break <= (i == 2);
            wr(REG_CTRL, {29'h0, md[i]});
            run(1'b1, 1'b0, 8);
            run(1'b0, 1'b0, 3);
            run(1'b1, 1'b1, (i == 6) ? 12 : 6);
            if (i < 3) `CHK("write_only", 1'b1, nr == 0 && na > 0)
            else if (i < 6) `CHK("read_only", 1'b1, na == 0 && nr > 0)
            else if (i == 6) `CHK("alternate", 1'b1, nsw >= 7)
            else `CHK("burst", 0, nsw)
            run(1'b0, 1'b1, 40);
            `CHK("drained", 1'b1, empty)
        end
        $display("test modes done");
    endtask
    task automatic conclude;
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        #(25ns * 30000);
        failures++;
        conclude;
    end
    initial begin
        {rst_n, reg_wr, reg_rd, go_push, go_pop, tie_break, pend} = '0;
        reg_addr = 4'h0;
        reg_wdata = 32'h0;
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        t_reset;
        t_fill(1'b0);
        t_override;
        t_modes;
        t_fill(1'b1);
        conclude;
    end
endmodule
`undef CHK
`default_nettype wire
